// *** edc_power_ctrl.sv ***
// Behaviour
// - mode works only while enable bit set
// - auto power-up when data count reaches threshold
// - auto power-down when no line energy
// - manual bit toggles state, then self-clears
// - burst of four pulses per power-up
// - burst disabled gives one pulse
// - power state bit shows up or down
// - power state meaningless while mode disabled
// - error threshold flag, informational, clear on read
// - data threshold flag, clear on read
// - error threshold field sets error count
// - data threshold field, resets to one
// - counters clear after two idle seconds
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ns
module edc_power_ctrl
  import edc_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = int'(EDC_IDLE_CYC),
  parameter int          PULSE_CYC   = int'(EDC_PULSE_CYC),
  parameter int          GAP_CYC     = int'(EDC_GAP_CYC)
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  input  wire logic        ED_DATA_EVENT_I,
  input  wire logic        ED_ERROR_EVENT_I,
  input  wire logic        LINE_ENERGY_I,
  output logic             CURRENT_DRIVER_ON_O,
  output logic             ED_PULSE_O,
  output logic             IRQ_O
);
  logic [1:0]           rst_sync;
  logic                 rst_n;
  logic [2:0]           data_sync;
  logic [2:0]           err_sync;
  logic [2:0]           energy_sync;
  logic                 data_lvl;
  logic                 err_lvl;
  logic                 energy_lvl;
  logic                 data_lvl_q;
  logic                 err_lvl_q;
  logic                 data_ev;
  logic                 err_ev;
  logic                 edet_enable;
  logic                 edet_auto_power_up;
  logic                 edet_auto_power_down;
  logic                 edet_manual_toggle;
  logic                 edet_pulse_burst_disable;
  logic                 edet_error_threshold_met;
  logic                 edet_data_threshold_met;
  logic [3:0]           edet_error_threshold;
  logic [3:0]           edet_data_threshold;
  logic                 edet_power_state;
  edc_pwr_t             pwr;
  edc_pwr_t             next_pwr;
  logic                 cnt_clear;
  logic                 idle_expired;
  logic [31:0]          idle_cnt;
  logic                 data_met;
  logic                 data_hit;
  logic                 err_hit;
  logic                 pwr_up_start;
  logic                 pwr_change;
  logic [EDC_IRQ_W-1:0] irq_status;
  logic [EDC_IRQ_W-1:0] irq_enable;
  logic [EDC_IRQ_W-1:0] irq_events;
  logic [EDC_IRQ_W-1:0] irq_clr;
  logic                 aw_full;
  logic                 w_full;
  logic [7:0]           aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 wr_do;
  logic                 rd_do;
  logic                 ctrl_read;
  logic [31:0]          rd_word;
  logic                 rd_ok;

  // address decode, shared by both channels
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == EDC_CTRL_ADDR) || (a == EDC_STS_ADDR) ||
                (a == EDC_CLR_ADDR) || (a == EDC_IEN_ADDR);
  endfunction

  // async assert, release through two flops
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // pins pass three flops; a level counts once stages two and three agree
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      data_sync   <= 3'h0;
      err_sync    <= 3'h0;
      energy_sync <= 3'h0;
      data_lvl    <= 1'b0;
      err_lvl     <= 1'b0;
      energy_lvl  <= 1'b0;
      data_lvl_q  <= 1'b0;
      err_lvl_q   <= 1'b0;
    end else begin
      data_sync   <= {data_sync[1:0], ED_DATA_EVENT_I};
      data_lvl_q  <= data_lvl;
      err_lvl_q   <= err_lvl;
      err_sync    <= {err_sync[1:0], ED_ERROR_EVENT_I};
      energy_sync <= {energy_sync[1:0], LINE_ENERGY_I};
      if (data_sync[1] == data_sync[2]) begin
        data_lvl <= data_sync[2];
      end
      if (err_sync[1] == err_sync[2]) begin
        err_lvl <= err_sync[2];
      end
      if (energy_sync[1] == energy_sync[2]) begin
        energy_lvl <= energy_sync[2];
      end
    end
  end

  // one event per rising edge of the filtered level, never one per held cycle
  assign data_ev = data_lvl && !data_lvl_q;
  assign err_ev  = err_lvl && !err_lvl_q;
  // idle timer restarts on every data event
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt <= 32'h0;
    end else if (data_ev || !edet_enable || idle_expired) begin
      idle_cnt <= 32'h0;
    end else begin
      idle_cnt <= idle_cnt + 32'h1;
    end
  end
  assign idle_expired = (idle_cnt >= IDLE_CYCLES - 1);

  // counters restart after idle time and after each state change
  assign cnt_clear = idle_expired || pwr_change || !edet_enable;

  edc_event_counter #(
    .W (EDC_THR_W)
  ) u_data_cnt (
    .clk_i   (REF_CLK_I),
    .rst_n_i (rst_n),
    .event_i (data_ev && edet_enable),
    .clear_i (cnt_clear),
    .thr_i   (edet_data_threshold),
    .count_o (),
    .met_o   (data_met),
    .hit_o   (data_hit)
  );

  edc_event_counter #(
    .W (EDC_THR_W)
  ) u_err_cnt (
    .clk_i   (REF_CLK_I),
    .rst_n_i (rst_n),
    .event_i (err_ev && edet_enable),
    .clear_i (cnt_clear),
    .thr_i   (edet_error_threshold),
    .count_o (),
    .met_o   (),
    .hit_o   (err_hit)
  );
  // power state decision; manual toggle wins over the automatic paths
  always_comb begin
    next_pwr = pwr;
    if (edet_enable && edet_manual_toggle) begin
      next_pwr = (pwr == EDC_ST_UP) ? EDC_ST_DOWN : EDC_ST_UP;
    end else if (edet_enable) begin
      unique case (pwr)
        EDC_ST_DOWN: begin
          if (edet_auto_power_up && data_met) begin
            next_pwr = EDC_ST_UP;
          end
        end
        EDC_ST_UP: begin
          if (edet_auto_power_down && !energy_lvl) begin
            next_pwr = EDC_ST_DOWN;
          end
        end
        default: next_pwr = EDC_ST_DOWN;
      endcase
    end
  end

  // state and driver move on one edge; driver stays powered while the mode is off
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      pwr                 <= EDC_ST_DOWN;
      CURRENT_DRIVER_ON_O <= 1'b1;
    end else begin
      pwr                 <= next_pwr;
      CURRENT_DRIVER_ON_O <= !edet_enable || (next_pwr == EDC_ST_UP);
    end
  end
  assign pwr_change   = (next_pwr != pwr);
  assign pwr_up_start = pwr_change && (next_pwr == EDC_ST_UP);
  assign edet_power_state = (pwr == EDC_ST_UP);

  edc_pulse_burst #(
    .PULSE_CYC (PULSE_CYC),
    .GAP_CYC   (GAP_CYC),
    .BURST     (EDC_BURST_LEN)
  ) u_burst (
    .clk_i    (REF_CLK_I),
    .rst_n_i  (rst_n),
    .start_i  (pwr_up_start),
    .single_i (edet_pulse_burst_disable),
    .pulse_o  (ED_PULSE_O),
    .busy_o   ()
  );

  // write side: address and data are held until both have arrived
  assign S_AXI_AWREADY_O = !aw_full && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O  = !w_full && !S_AXI_BVALID_O;
  assign wr_do = aw_full && w_full;

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      aw_full        <= 1'b0;
      w_full         <= 1'b0;
      aw_addr        <= 8'h00;
      w_data         <= 32'h0;
      w_strb         <= 4'h0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= EDC_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_full <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_full <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
      end
      if (wr_do) begin
        aw_full        <= 1'b0;
        w_full         <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= is_mapped(aw_addr) ? EDC_RESP_OKAY : EDC_RESP_SLVERR;
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // control register fields, byte lanes honoured
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      edet_enable              <= EDC_RST_EN;
      edet_auto_power_up       <= EDC_RST_AUTO_UP;
      edet_auto_power_down     <= EDC_RST_AUTO_DN;
      edet_pulse_burst_disable <= EDC_RST_BURST_DIS;
      edet_error_threshold     <= EDC_RST_ERR_THR;
      edet_data_threshold      <= EDC_RST_DATA_THR;
      edet_manual_toggle       <= 1'b0;
    end else begin
      edet_manual_toggle <= 1'b0;
      if (wr_do && aw_addr == EDC_CTRL_ADDR) begin
        if (w_strb[1]) begin
          edet_enable              <= w_data[EDC_B_EN];
          edet_auto_power_up       <= w_data[EDC_B_AUTO_UP];
          edet_auto_power_down     <= w_data[EDC_B_AUTO_DN];
          edet_manual_toggle       <= w_data[EDC_B_MANUAL];
          edet_pulse_burst_disable <= w_data[EDC_B_BURST_DIS];
        end
        if (w_strb[0]) begin
          edet_error_threshold <= w_data[EDC_F_ERR_LSB +: EDC_THR_W];
          edet_data_threshold  <= w_data[EDC_F_DATA_LSB +: EDC_THR_W];
        end
      end
    end
  end

  // read side: one read in flight, data registered
  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
  assign rd_do     = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  assign ctrl_read = rd_do && (S_AXI_ARADDR_I == EDC_CTRL_ADDR);

  always_comb begin
    rd_word = 32'h0;
    rd_ok   = is_mapped(S_AXI_ARADDR_I);
    unique case (S_AXI_ARADDR_I)
      EDC_CTRL_ADDR: begin
        rd_word[EDC_B_EN]        = edet_enable;
        rd_word[EDC_B_AUTO_UP]   = edet_auto_power_up;
        rd_word[EDC_B_AUTO_DN]   = edet_auto_power_down;
        rd_word[EDC_B_MANUAL]    = edet_manual_toggle;
        rd_word[EDC_B_BURST_DIS] = edet_pulse_burst_disable;
        rd_word[EDC_B_PWR]       = edet_power_state;
        rd_word[EDC_B_ERR_MET]   = edet_error_threshold_met;
        rd_word[EDC_B_DATA_MET]  = edet_data_threshold_met;
        rd_word[EDC_F_ERR_LSB +: EDC_THR_W]  = edet_error_threshold;
        rd_word[EDC_F_DATA_LSB +: EDC_THR_W] = edet_data_threshold;
      end
      EDC_STS_ADDR: rd_word[EDC_IRQ_W-1:0] = irq_status;
      EDC_IEN_ADDR: rd_word[EDC_IRQ_W-1:0] = irq_enable;
      default:      rd_word = 32'h0; // clear reg and holes read zero
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= 32'h0;
      S_AXI_RRESP_O  <= EDC_RESP_OKAY;
    end else if (rd_do) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O  <= rd_word;
      S_AXI_RRESP_O  <= rd_ok ? EDC_RESP_OKAY : EDC_RESP_SLVERR;
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end
  // clear-on-read flags; a new hit in the read cycle survives it
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      edet_error_threshold_met <= 1'b0;
      edet_data_threshold_met  <= 1'b0;
    end else begin
      edet_error_threshold_met <= err_hit || (edet_error_threshold_met && !ctrl_read);
      edet_data_threshold_met  <= data_hit || (edet_data_threshold_met && !ctrl_read);
    end
  end

  // interrupt status, enable and write-one clear
  assign irq_events = {pwr_change && edet_enable, err_hit, data_hit};
  assign irq_clr = (wr_do && aw_addr == EDC_CLR_ADDR && w_strb[0]) ?
                   w_data[EDC_IRQ_W-1:0] : '0;

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
      irq_enable <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_events; // set wins
      if (wr_do && aw_addr == EDC_IEN_ADDR && w_strb[0]) begin
        irq_enable <= w_data[EDC_IRQ_W-1:0];
      end
    end
  end

  assign IRQ_O = |(irq_status & irq_enable);
endmodule

// *** edc_pkg.sv ***
package edc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] EDC_CTRL_IDX = 8'h1d;
  localparam logic [7:0] EDC_STS_IDX  = 8'h20;
  localparam logic [7:0] EDC_CLR_IDX  = 8'h21;
  localparam logic [7:0] EDC_IEN_IDX  = 8'h22;
  localparam logic [7:0] EDC_CTRL_ADDR = {EDC_CTRL_IDX[5:0], 2'b00};
  localparam logic [7:0] EDC_STS_ADDR  = {EDC_STS_IDX[5:0], 2'b00};
  localparam logic [7:0] EDC_CLR_ADDR  = {EDC_CLR_IDX[5:0], 2'b00};
  localparam logic [7:0] EDC_IEN_ADDR  = {EDC_IEN_IDX[5:0], 2'b00};

  // control register field positions
  localparam int EDC_B_EN       = 15;
  localparam int EDC_B_AUTO_UP  = 14;
  localparam int EDC_B_AUTO_DN  = 13;
  localparam int EDC_B_MANUAL   = 12;
  localparam int EDC_B_BURST_DIS = 11;
  localparam int EDC_B_PWR      = 10;
  localparam int EDC_B_ERR_MET  = 9;
  localparam int EDC_B_DATA_MET = 8;
  localparam int EDC_F_ERR_LSB  = 4;
  localparam int EDC_F_DATA_LSB = 0;
  localparam int EDC_THR_W      = 4;

  // control register reset values
  localparam logic       EDC_RST_EN       = 1'b0;
  localparam logic       EDC_RST_AUTO_UP  = 1'b1;
  localparam logic       EDC_RST_AUTO_DN  = 1'b1;
  localparam logic       EDC_RST_BURST_DIS = 1'b0;
  localparam logic [3:0] EDC_RST_ERR_THR  = 4'h0;
  localparam logic [3:0] EDC_RST_DATA_THR = 4'h1;

  // interrupt status layout
  localparam int EDC_IRQ_W        = 3;
  localparam int EDC_I_DATA_MET   = 0;
  localparam int EDC_I_ERR_MET    = 1;
  localparam int EDC_I_PWR_CHANGE = 2;

  // timing
  localparam longint EDC_CLK_PERIOD_NS = 10;
  localparam longint EDC_IDLE_TIME_MS  = 2000;
  localparam longint EDC_IDLE_CYC =
    EDC_IDLE_TIME_MS * 1000000 / EDC_CLK_PERIOD_NS;
  localparam longint EDC_PULSE_TIME_NS = 100;
  localparam longint EDC_PULSE_CYC =
    (EDC_PULSE_TIME_NS + EDC_CLK_PERIOD_NS - 1) / EDC_CLK_PERIOD_NS;
  localparam longint EDC_GAP_TIME_NS = 1000;
  localparam longint EDC_GAP_CYC =
    (EDC_GAP_TIME_NS + EDC_CLK_PERIOD_NS - 1) / EDC_CLK_PERIOD_NS;
  localparam int     EDC_BURST_LEN = 4;

  // axi responses
  localparam logic [1:0] EDC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] EDC_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    EDC_ST_DOWN = 2'b01,
    EDC_ST_UP   = 2'b10
  } edc_pwr_t;
endpackage

// *** edc_event_counter.sv ***
`timescale 1ns/1ns
module edc_event_counter
  import edc_pkg::*;
#(
  parameter int W = EDC_THR_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         event_i,
  input  wire logic         clear_i,
  input  wire logic [W-1:0] thr_i,
  output logic      [W-1:0] count_o,
  output logic              met_o,
  output logic              hit_o
);
  logic [W-1:0] next_count;
  logic [W-1:0] eff_thr;

  // saturating step; a zero threshold behaves as one
  always_comb begin
    next_count = (&count_o) ? count_o : W'(count_o + 1'b1);
    eff_thr    = (thr_i == '0) ? W'(1) : thr_i;
  end

  // level compare every cycle, hit marks each event that reaches or passes it
  assign met_o = (count_o >= eff_thr);
  assign hit_o = event_i && (next_count >= eff_thr) && !clear_i;

  // clear has priority so a stale count never leaks past a reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= '0;
    end else if (clear_i) begin
      count_o <= '0;
    end else if (event_i) begin
      count_o <= next_count;
    end
  end
endmodule

// *** edc_pulse_burst.sv ***
`timescale 1ns/1ns
module edc_pulse_burst
  import edc_pkg::*;
#(
  parameter int PULSE_CYC = int'(EDC_PULSE_CYC),
  parameter int GAP_CYC   = int'(EDC_GAP_CYC),
  parameter int BURST     = EDC_BURST_LEN
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic start_i,
  input  wire logic single_i,
  output logic      pulse_o,
  output logic      busy_o
);
  logic [7:0] left;
  logic [7:0] timer;

  // a start while busy is ignored; one burst per power-up
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left    <= 8'h00;
      timer   <= 8'h00;
      pulse_o <= 1'b0;
      busy_o  <= 1'b0;
    end else if (!busy_o) begin
      if (start_i) begin
        busy_o  <= 1'b1;
        pulse_o <= 1'b1;
        timer   <= 8'(PULSE_CYC - 1);
        left    <= single_i ? 8'h00 : 8'(BURST - 1);
      end
    end else if (timer != 8'h00) begin
      timer <= timer - 8'h01;
    end else if (pulse_o) begin
      pulse_o <= 1'b0;
      timer   <= 8'(GAP_CYC - 1);
      busy_o  <= (left != 8'h00);
    end else begin
      pulse_o <= 1'b1;
      timer   <= 8'(PULSE_CYC - 1);
      left    <= left - 8'h01;
    end
  end
endmodule

// *** edc_power_ctrl_chk.sv ***
`timescale 1ns/1ns
module edc_power_ctrl_chk
  import edc_pkg::*;
#(
  parameter int PULSE_CYC = 2
) (
  input wire logic        REF_CLK_I,
  input wire logic        RSTN_I,
  input wire logic        S_AXI_AWREADY_O,
  input wire logic        S_AXI_WREADY_O,
  input wire logic [1:0]  S_AXI_BRESP_O,
  input wire logic        S_AXI_BVALID_O,
  input wire logic        S_AXI_BREADY_I,
  input wire logic        S_AXI_ARVALID_I,
  input wire logic        S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic        S_AXI_RVALID_O,
  input wire logic        S_AXI_RREADY_I,
  input wire logic        ED_PULSE_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);

  // pulse width counter, saturating so a stuck pin cannot wrap back
  logic [7:0] hi_cnt;
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      hi_cnt <= 8'h00;
    end else if (ED_PULSE_O) begin
      hi_cnt <= (hi_cnt == 8'hff) ? hi_cnt : hi_cnt + 8'h01;
    end else begin
      hi_cnt <= 8'h00;
    end
  end

  // both halves of a write held, response not yet out
  sequence s_wr_held;
    !S_AXI_AWREADY_O && !S_AXI_WREADY_O && !S_AXI_BVALID_O;
  endsequence
  sequence s_rd_take;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  endsequence

  AST_WR_ANSWER: assert property (s_wr_held |=> S_AXI_BVALID_O)
    else $error("write response not one cycle after hold");
  AST_RD_ANSWER: assert property (s_rd_take |=> S_AXI_RVALID_O)
    else $error("read data not one cycle after address");
  AST_B_STANDS: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
    |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
    else $error("write response dropped early");
  AST_R_STANDS: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
    |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read data dropped early");
  AST_R_DROP: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O)
    else $error("read data stays after handshake");
  AST_W_REFUSE: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write accepted while response pending");
  AST_AR_REFUSE: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
    else $error("read accepted while data pending");
  AST_PULSE_LEN: assert property ($fell(ED_PULSE_O) |-> hi_cnt == PULSE_CYC)
    else $error("pulse width wrong");
endmodule

bind edc_power_ctrl edc_power_ctrl_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (
  .REF_CLK_I       (REF_CLK_I),
  .RSTN_I          (RSTN_I),
  .S_AXI_AWREADY_O (S_AXI_AWREADY_O),
  .S_AXI_WREADY_O  (S_AXI_WREADY_O),
  .S_AXI_BRESP_O   (S_AXI_BRESP_O),
  .S_AXI_BVALID_O  (S_AXI_BVALID_O),
  .S_AXI_BREADY_I  (S_AXI_BREADY_I),
  .S_AXI_ARVALID_I (S_AXI_ARVALID_I),
  .S_AXI_ARREADY_O (S_AXI_ARREADY_O),
  .S_AXI_RDATA_O   (S_AXI_RDATA_O),
  .S_AXI_RVALID_O  (S_AXI_RVALID_O),
  .S_AXI_RREADY_I  (S_AXI_RREADY_I),
  .ED_PULSE_O      (ED_PULSE_O)
);

// *** edc_power_ctrl_tb.sv ***
`timescale 1ns/1ns
module edc_power_ctrl_tb
  import edc_pkg::*;
;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] wd;
    logic [31:0] m;
    logic [31:0] x;
    logic [1:0]  rs;
  } edc_row_t;

  logic        clk;
  logic        rst_n;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        ev_data, ev_err, energy;
  logic        drv_on, pulse, irq;
  int          n_mismatch, checks, pcount;

  // address, write, read mask, expected read, response
  edc_row_t rows [5] = '{
    '{EDC_CTRL_ADDR, 32'h0000_1ff3, 32'h0000_fbff, 32'h0000_08f3, EDC_RESP_OKAY},
    '{EDC_CTRL_ADDR, 32'h0000_6001, 32'h0000_fbff, 32'h0000_6001, EDC_RESP_OKAY},
    '{EDC_IEN_ADDR, 32'h0000_0007, 32'hffff_ffff, 32'h0000_0007, EDC_RESP_OKAY},
    '{EDC_CLR_ADDR, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_0000, EDC_RESP_OKAY},
    '{8'hfc, 32'h0000_1234, 32'hffff_ffff, 32'h0000_0000, EDC_RESP_SLVERR}
  };

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // pulse count; a glitch would show as an extra pulse
  always @(posedge pulse) pcount++;

  // short idle and pulse counts keep the run small
  edc_power_ctrl #(.IDLE_CYCLES(200), .PULSE_CYC(2), .GAP_CYC(3)) dut (
    .REF_CLK_I           (clk),
    .RSTN_I              (rst_n),
    .S_AXI_AWADDR_I      (awaddr),
    .S_AXI_AWVALID_I     (awvalid),
    .S_AXI_AWREADY_O     (awready),
    .S_AXI_WDATA_I       (wdata),
    .S_AXI_WSTRB_I       (4'hf),
    .S_AXI_WVALID_I      (wvalid),
    .S_AXI_WREADY_O      (wready),
    .S_AXI_BRESP_O       (bresp),
    .S_AXI_BVALID_O      (bvalid),
    .S_AXI_BREADY_I      (bready),
    .S_AXI_ARADDR_I      (araddr),
    .S_AXI_ARVALID_I     (arvalid),
    .S_AXI_ARREADY_O     (arready),
    .S_AXI_RDATA_O       (rdata),
    .S_AXI_RRESP_O       (rresp),
    .S_AXI_RVALID_O      (rvalid),
    .S_AXI_RREADY_I      (rready),
    .ED_DATA_EVENT_I     (ev_data),
    .ED_ERROR_EVENT_I    (ev_err),
    .LINE_ENERGY_I       (energy),
    .CURRENT_DRIVER_ON_O (drv_on),
    .ED_PULSE_O          (pulse),
    .IRQ_O               (irq)
  );

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic tmo();
    n_mismatch++;
    end_of_test();
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ready is raised only once the answer is seen, so the slave must hold it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    r = bresp;
    if (n == 40) tmo();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    d = rdata;
    r = rresp;
    if (n == 40) tmo();
  endtask

  // pins pass a three-stage synchroniser, so hold each level three cycles
  task automatic ev(input logic err);
    if (err) ev_err <= 1'b1;
    else ev_data <= 1'b1;
    idle(3);
    ev_err <= 1'b0;
    ev_data <= 1'b0;
    idle(3);
  endtask

  task automatic wait_drv(input logic v);
    int n;
    for (n = 0; n < 30 && drv_on !== v; n++) @(posedge clk);
    if (n == 30) tmo();
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    rst_n <= 1'b0;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    arvalid <= 1'b0;
    bready <= 1'b0;
    rready <= 1'b0;
    awaddr <= 8'h00;
    araddr <= 8'h00;
    wdata <= 32'h0;
    ev_data <= 1'b0;
    ev_err <= 1'b0;
    energy <= 1'b1;
    idle(20);
    rst_n <= 1'b1;
    idle(3);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].wd, r);
      chk("wresp", r, rows[i].rs);
      rd(rows[i].a, d, r);
      chk("rresp", r, rows[i].rs);
      chk("rdata", d & rows[i].m, rows[i].x);
    end
    $display("test table done");
    // reset again in mid-run
    rst_n <= 1'b0;
    idle(20);
    rst_n <= 1'b1;
    idle(3);
    rd(EDC_CTRL_ADDR, d, r);
    chk("ctrl reset", d & 32'hfbff, 32'h6001);
    rd(EDC_STS_ADDR, d, r);
    chk("status reset", d, 32'h0);
    $display("test reset done");
    // data threshold of three drives power-up and a four-pulse burst
    wr(EDC_IEN_ADDR, 32'h5, r);
    wr(EDC_CTRL_ADDR, 32'he023, r); // crossover control lives outside this block
    ev(1'b0);
    ev(1'b0);
    idle(8);
    chk("early up", drv_on, 1'b0);
    pcount = 0;
    ev(1'b0);
    wait_drv(1'b1);
    idle(25);
    chk("burst", pcount, 4);
    ev(1'b1);
    ev(1'b1);
    idle(6);
    rd(EDC_CTRL_ADDR, d, r);
    chk("flags", d & 32'h0700, 32'h0700);
    rd(EDC_CTRL_ADDR, d, r);
    chk("flags cor", d & 32'h0700, 32'h0400);
    rd(EDC_STS_ADDR, d, r);
    chk("status", d, 32'h7);
    wr(EDC_CLR_ADDR, 32'h5, r);
    chk("irq masked", irq, 1'b0);
    wr(EDC_IEN_ADDR, 32'h7, r);
    chk("irq on", irq, 1'b1);
    wr(EDC_CLR_ADDR, 32'h7, r);
    chk("irq off", irq, 1'b0);
    $display("test power up done");
    energy <= 1'b0;
    wait_drv(1'b0);
    rd(EDC_CTRL_ADDR, d, r);
    chk("down", d & 32'h0400, 32'h0);
    $display("test power down done");
    // two events, idle window expires, so the third must not count as third
    energy <= 1'b1;
    ev(1'b0);
    ev(1'b0);
    idle(250);
    ev(1'b0);
    idle(8);
    chk("idle clear", drv_on, 1'b0);
    ev(1'b0);
    ev(1'b0);
    wait_drv(1'b1);
    idle(25);
    $display("test idle done");
    // manual toggle down then up with a single pulse, interrupt cleared first
    wr(EDC_CLR_ADDR, 32'h7, r);
    chk("irq clear", irq, 1'b0);
    wr(EDC_CTRL_ADDR, 32'hd823, r);
    wait_drv(1'b0);
    chk("irq toggle", irq, 1'b1);
    pcount = 0;
    wr(EDC_CTRL_ADDR, 32'hd823, r);
    wait_drv(1'b1);
    idle(12);
    chk("single", pcount, 1);
    rd(EDC_CTRL_ADDR, d, r);
    chk("manual", d & 32'h1400, 32'h0400);
    $display("test manual done");
    wr(EDC_CTRL_ADDR, 32'h4001, r);
    ev(1'b0);
    idle(8);
    rd(EDC_CTRL_ADDR, d, r);
    chk("disabled", d & 32'h0100, 32'h0);
    chk("drv on", drv_on, 1'b1);
    $display("test disabled done");
    end_of_test();
  end
endmodule
